// *** hw/tec_top.sv ***
/*
 * 16-bit count-up timer/event counter with preload, byte access
 * through a low-byte buffer, and an APB register slave.
 * Assumes all inputs are synchronous to CORE_CLK_I.
 */
// The implementer's own choice: the APB slave port.
// What this block does
// - sixteen-bit up-counter, clocked from the pin or internally
// - timer and pulse modes advance at system clock over four
// - event mode counts selected pin edges
// - low byte write fills only the low buffer
// - high byte write loads whole preload from it and buffer
// - high byte read latches counter low byte into buffer
// - low byte read returns the buffer
// - control bits 7:6 select event, timer or pulse mode
// - control bit 3 picks rising (0) or falling (1) edge
// - overflow past FFFF reloads preload and sets request flag
// - pulse mode counts from active edge until level returns
// - pulse mode is edge triggered, not level triggered
// - one measurement only until enable is set again
// - pulse mode overflow reloads and requests as well
// - counting only while control bit 4 is set
// - enable auto-clears only at pulse measurement end
// - overflow is a wake-up event
// - interrupt enable at zero suppresses service in every mode
// - preload write while stopped also loads the counter
// - preload write while running leaves counter alone
// - reading the high byte blocks the count clock
// - control bits 2:0 and 5 read as zero
`timescale 1ns/100ps
`include "tec_regs.svh"

module tec_top #(
    parameter int PRESCALE = `TEC_PRESCALE
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic EVENT_PIN_I,
    output logic IRQ_O,
    output logic WAKE_O,
    output logic [15:0] COUNT_O
);
    localparam logic [1:0] PS_LAST = 2'(PRESCALE - 1);

    function automatic logic idx_hit(input logic [11:0] a, input logic [7:0] idx);
        idx_hit = (a[1:0] == 2'h0) && (a[11:2] == {2'h0, idx});
    endfunction : idx_hit

    tec_pkg::tec_apb_req_t req;
    assign req = '{sel: PSEL_I, en: PENABLE_I, wr: PWRITE_I,
                   addr: PADDR_I, wdata: PWDATA_I};

    logic [15:0] count;
    logic [15:0] preload;
    logic [7:0] low_buf;
    logic [7:0] ctrl;
    logic [7:0] irq_reg;
    logic [1:0] ps_cnt;
    logic pin_prev;
    tec_pkg::tec_pw_t pw_state;

    // bus decode
    wire hit_high = idx_hit(req.addr, `TEC_IDX_HIGH);
    wire hit_low = idx_hit(req.addr, `TEC_IDX_LOW);
    wire hit_ctrl = idx_hit(req.addr, `TEC_IDX_CTRL);
    wire hit_irq = idx_hit(req.addr, `TEC_IDX_IRQ);
    wire mapped = hit_high | hit_low | hit_ctrl | hit_irq;
    wire access = req.sel & req.en;
    wire first_acc = access & ~PREADY_O;
    wire done = access & PREADY_O;
    wire wr_done = done & req.wr & mapped;
    wire rd_done = done & ~req.wr & mapped;
    wire wr_high = wr_done & hit_high;
    wire wr_low = wr_done & hit_low;
    wire wr_ctrl = wr_done & hit_ctrl;
    wire wr_irq = wr_done & hit_irq;
    wire rd_high = rd_done & hit_high;

    // control fields
    tec_pkg::tec_mode_t mode;
    assign mode = tec_pkg::tec_mode_t'(ctrl[`TEC_CTRL_MODE_HI:`TEC_CTRL_MODE_LO]);
    wire enable = ctrl[`TEC_CTRL_EN];
    wire edge_polarity = ctrl[`TEC_CTRL_EDGE];
    wire irq_enable = irq_reg[`TEC_IRQ_IE];
    wire irq_flag = irq_reg[`TEC_IRQ_FLAG];

    wire tick = (ps_cnt == PS_LAST);
    wire [1:0] next_ps = tick ? 2'h0 : ps_cnt + 2'h1;

    wire rise = EVENT_PIN_I & ~pin_prev;
    wire fall = ~EVENT_PIN_I & pin_prev;
    wire act_edge = edge_polarity ? fall : rise;
    wire back_edge = edge_polarity ? rise : fall;

    // read of the high byte holds the count clock
    wire blk = access & ~req.wr & hit_high;

    // pulse measurement start and end, edges only
    wire pw_mode = (mode == tec_pkg::MODE_PULSE);
    wire pw_start = pw_mode & enable & (pw_state == tec_pkg::PW_WAIT) & act_edge;
    wire pw_end = pw_mode & (pw_state == tec_pkg::PW_MEAS) & back_edge;
    wire pw_run = pw_mode & enable & (pw_state == tec_pkg::PW_MEAS);

    // source by mode; mode 00 never advances
    logic src;
    always_comb begin
        case (mode)
            tec_pkg::MODE_EVENT: src = act_edge;
            tec_pkg::MODE_TIMER: src = tick;
            tec_pkg::MODE_PULSE: src = tick & pw_run;
            default: src = 1'b0;
        endcase
    end

    // enable gates counting; one counter for all modes
    wire adv = src & enable & ~blk;
    wire ovf = adv & (count == `TEC_TOP);

    wire [15:0] run_next = ovf ? preload : count + 16'h0001;
    wire [15:0] next_preload = wr_high ? {req.wdata[7:0], low_buf} : preload;

    // stopped: write reaches the counter; running: not
    logic [15:0] next_count;
    always_comb begin
        if (wr_high && !enable) begin
            next_count = next_preload;
        end else if (adv) begin
            next_count = run_next;
        end else begin
            next_count = count;
        end
    end

    // low write to buffer; high read latches live low byte
    wire [7:0] next_low_buf = wr_low ? req.wdata[7:0] :
                              rd_high ? count[7:0] : low_buf;

    // hardware clears enable only at pulse end; software wins
    wire [7:0] ctrl_wr = req.wdata[7:0] & `TEC_CTRL_MASK;
    wire [7:0] pw_clr = {3'h7, ~pw_end, 4'hF};
    wire [7:0] next_ctrl = wr_ctrl ? ctrl_wr : ctrl & pw_clr;

    // flag set wins over software clear
    wire [7:0] irq_wr = req.wdata[7:0] & `TEC_IRQ_MASK;
    wire [7:0] irq_kept = wr_irq ? (irq_wr & irq_reg) | (irq_wr & 8'h01) : irq_reg;
    wire [7:0] next_irq = {irq_kept[7], irq_kept[6] | ovf, irq_kept[5:0]};

    // wait state only re-arms via a fresh enable
    logic [1:0] next_pw;
    always_comb begin
        case (pw_state)
            tec_pkg::PW_WAIT: next_pw = pw_start ? tec_pkg::PW_MEAS : tec_pkg::PW_WAIT;
            tec_pkg::PW_MEAS: next_pw = (pw_end || !pw_mode || !enable) ?
                                        tec_pkg::PW_WAIT : tec_pkg::PW_MEAS;
            default: next_pw = tec_pkg::PW_WAIT;
        endcase
    end

    // low read gives buffer; unused control bits zero
    logic [7:0] rd_val;
    always_comb begin
        case (1'b1)
            hit_high: rd_val = count[15:8];
            hit_low: rd_val = low_buf;
            hit_ctrl: rd_val = ctrl & `TEC_CTRL_MASK;
            hit_irq: rd_val = irq_reg & `TEC_IRQ_MASK;
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            count <= 16'h0000;
            preload <= 16'h0000;
            low_buf <= 8'h00;
            ctrl <= `TEC_CTRL_RST;
            irq_reg <= `TEC_IRQ_RST;
            ps_cnt <= 2'h0;
            pin_prev <= 1'b0;
            pw_state <= tec_pkg::PW_WAIT;
        end else begin
            count <= next_count;
            preload <= next_preload;
            low_buf <= next_low_buf;
            ctrl <= next_ctrl;
            irq_reg <= next_irq;
            ps_cnt <= next_ps;
            pin_prev <= EVENT_PIN_I;
            pw_state <= tec_pkg::tec_pw_t'(next_pw);
        end
    end

    // bus answer: one wait state, registered outputs
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
        end else begin
            PREADY_O <= first_acc;
            PSLVERR_O <= first_acc & ~mapped;
            PRDATA_O <= (first_acc & ~req.wr) ? {24'h00_0000, rd_val} : 32'h0000_0000;
        end
    end

    // wake pulse on overflow; enable gates the request
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            IRQ_O <= 1'b0;
            WAKE_O <= 1'b0;
            COUNT_O <= 16'h0000;
        end else begin
            IRQ_O <= next_irq[`TEC_IRQ_FLAG] & next_irq[`TEC_IRQ_IE];
            WAKE_O <= ovf;
            COUNT_O <= next_count;
        end
    end

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    sequence s_pw_end;
        pw_end ##1 !enable;
    endsequence

    sequence s_pw_start;
        pw_start ##1 pw_state == tec_pkg::PW_MEAS;
    endsequence

    a_tick_every_four: assert property (
        tick |=> !tick [*3] ##1 tick)
        else $error("prescale tick not every fourth cycle");

    a_low_write_buf: assert property (
        wr_low & !wr_high |=> $stable(preload) && low_buf == $past(req.wdata[7:0]))
        else $error("low byte write touched preload");

    a_high_write_pre: assert property (
        wr_high |=> preload == {$past(req.wdata[7:0]), $past(low_buf)})
        else $error("preload not loaded from high write");

    a_high_read_cap: assert property (
        rd_high |=> low_buf == $past(count[7:0]))
        else $error("high read did not latch low byte");

    a_low_read_buf: assert property (
        PREADY_O & !req.wr & hit_low |-> PRDATA_O[7:0] == low_buf)
        else $error("low read did not return buffer");

    a_ovf_reload_flag: assert property (
        ovf |=> count == $past(preload) && irq_flag)
        else $error("overflow reload or flag wrong");

    a_pw_end_clear: assert property (
        pw_end & !wr_ctrl |-> s_pw_end)
        else $error("enable not cleared at pulse end");

    a_disabled_hold: assert property (
        !enable & !wr_high |=> $stable(count))
        else $error("counter moved while disabled");

    a_stopped_load: assert property (
        wr_high & !enable |=> count == $past(next_preload))
        else $error("stopped write did not load counter");

    a_read_block: assert property (
        blk |=> $stable(count))
        else $error("counter moved during high read");

    a_mode_off_idle: assert property (
        mode == tec_pkg::MODE_OFF & !wr_high |=> $stable(count) && !WAKE_O)
        else $error("counter moved in unused mode");

    a_irq_gate: assert property (
        !irq_enable & !wr_irq |=> !IRQ_O)
        else $error("interrupt raised while disabled");

    a_wake_pulse: assert property (
        ovf |=> WAKE_O)
        else $error("no wake pulse on overflow");

    a_count_up: assert property (
        adv && !ovf |=> count == $past(count) + 16'h0001)
        else $error("counter did not step by one");

    a_timer_rate: assert property (
        mode == tec_pkg::MODE_TIMER && enable && !tick |=> $stable(count))
        else $error("timer moved between ticks");

    a_event_step: assert property (
        mode == tec_pkg::MODE_EVENT && enable && act_edge && !blk && count != `TEC_TOP
        |=> count == $past(count) + 16'h0001)
        else $error("event edge not counted");

    a_pulse_source: assert property (
        pw_mode && pw_state != tec_pkg::PW_MEAS && !wr_high |=> $stable(count))
        else $error("pulse mode counted outside a measurement");

    a_wrong_edge: assert property (
        mode == tec_pkg::MODE_EVENT && back_edge && !wr_high |=> $stable(count))
        else $error("inactive edge was counted");

    a_pw_start_meas: assert property (
        pw_start |-> s_pw_start)
        else $error("measurement did not start on active edge");

    a_pw_edge_only: assert property (
        pw_state == tec_pkg::PW_WAIT && !act_edge |=> pw_state == tec_pkg::PW_WAIT)
        else $error("measurement started without an edge");

    a_pw_one_shot: assert property (
        pw_mode && !enable |=> pw_state == tec_pkg::PW_WAIT)
        else $error("measurement armed without enable");

    a_pw_ovf_reload: assert property (
        ovf && pw_mode |=> count == $past(preload) && WAKE_O)
        else $error("pulse mode overflow not reloaded");

    a_enable_kept: assert property (
        enable && !pw_end && !wr_ctrl |=> enable)
        else $error("enable dropped without cause");

    a_run_write_keep: assert property (
        wr_high && enable && !adv |=> $stable(count))
        else $error("running counter disturbed by preload write");

    a_unused_zero: assert property (
        PREADY_O && !req.wr && hit_ctrl |-> PRDATA_O[2:0] == 3'h0 && !PRDATA_O[5])
        else $error("unused control bits not zero");

endmodule : tec_top

// *** hw/tec_regs.svh ***
/*
 * Register indices, field positions, reset values and timing counts
 * of the 16-bit timer/event counter.
 * Assumes byte address = 4 * index on the register bus.
 */
`ifndef TEC_REGS_SVH
`define TEC_REGS_SVH
`define TEC_IDX_HIGH 8'h0C
`define TEC_IDX_LOW 8'h0D
`define TEC_IDX_CTRL 8'h0E
`define TEC_IDX_IRQ 8'h0F
`define TEC_CTRL_MODE_HI 7
`define TEC_CTRL_MODE_LO 6
`define TEC_CTRL_EN 4
`define TEC_CTRL_EDGE 3
`define TEC_IRQ_FLAG 6
`define TEC_IRQ_IE 0
`define TEC_CTRL_RST 8'h08
`define TEC_IRQ_RST 8'h00
`define TEC_CTRL_MASK 8'hD8
`define TEC_IRQ_MASK 8'h41
`define TEC_CLK_HZ 100000000
`define TEC_PRESCALE 4
`define TEC_TOP 16'hFFFF
`endif

// *** hw/tec_pkg.sv ***
/*
 * Types shared by the timer/event counter: modes, measure states and
 * the register-bus request carrier.
 * Assumes the constants header is included by the design file.
 */
package tec_pkg;
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_EVENT = 2'h1,
        MODE_TIMER = 2'h2,
        MODE_PULSE = 2'h3
    } tec_mode_t;

    typedef enum logic [1:0] {
        PW_WAIT = 2'h1,
        PW_MEAS = 2'h2
    } tec_pw_t;

    typedef struct packed {
        logic sel;
        logic en;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } tec_apb_req_t;
endpackage : tec_pkg

// *** bench/tec_pin_src.sv ***
/*
 * Pulse source on the timer pin: idle level plus bursts of pulses.
 * Assumes requests arrive as a one-cycle go strobe on the rising edge.
 */
`timescale 1ns/100ps

module tec_pin_src (
    input wire logic clk_i,
    input wire logic idle_i,
    input wire logic go_i,
    input wire logic [7:0] n_i,
    input wire logic [7:0] len_i,
    output logic pin_o,
    output logic busy_o
);
    logic act;

    // the pin sits at idle between pulses, a pulse is the opposite level
    assign pin_o = idle_i ^ act;

    initial begin
        act = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (go_i) begin
                busy_o <= 1'b1;
                for (int i = 0; i < n_i; i++) begin
                    act <= 1'b1;
                    repeat (len_i) @(posedge clk_i);
                    act <= 1'b0;
                    repeat (len_i) @(posedge clk_i);
                end
                busy_o <= 1'b0;
            end
        end
    end
endmodule : tec_pin_src

// *** bench/test_timer_event_counter_16bit.sv ***
/*
 * Self-checking bench: APB register tasks and pin pulse scenarios.
 * Assumes the counter top and the pin source model are compiled first.
 */
`timescale 1ns/100ps
`include "tec_regs.svh"

module test_timer_event_counter_16bit;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, irq, wake, pin, busy, rerr;
    logic [15:0] count, v;
    logic idle = 1'b0, go = 1'b0;
    logic [7:0] npulse = 8'h00, plen = 8'h00;
    int errors = 0, checks_done = 0, cycles = 0, wakes = 0, k, w0;

    tec_top #(.PRESCALE(4)) DUT (.CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .EVENT_PIN_I(pin),
        .IRQ_O(irq), .WAKE_O(wake), .COUNT_O(count));
    tec_pin_src src (.clk_i(clk), .idle_i(idle), .go_i(go), .n_i(npulse), .len_i(plen),
        .pin_o(pin), .busy_o(busy));

    initial begin
        forever #5 clk = ~clk;
    end

    task report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles++;
        if (wake === 1'b1) wakes++;
        if (cycles == 5000) begin
            errors++;
            report_and_stop;
        end
    end

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) errors++;
        rdv = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
        apb(1'b0, idx, 8'h00);
        chk(what, {24'h000000, exp}, rdv);
    endtask : rd

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task level(input logic l);
        @(posedge clk);
        idle <= l;
        tick(4);
    endtask : level

    task pulses(input logic [7:0] n, input logic [7:0] len);
        int t;
        @(posedge clk);
        npulse <= n;
        plen <= len;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (busy === 1'b1 && t < 3000);
        tick(2);
    endtask : pulses

    initial begin
        tick(4);
        rst_n <= 1'b1;
        rd(`TEC_IDX_CTRL, 8'h08, "ctrl reset");
        rd(`TEC_IDX_IRQ, 8'h00, "irq reset");
        rd(`TEC_IDX_HIGH, 8'h00, "high reset");
        apb(1'b0, 8'h10, 8'h00);
        chk("unmapped err", 32'h1, rerr);
        chk("unmapped data", 32'h0, rdv);
        wr(`TEC_IDX_LOW, 8'h34);
        chk("count after low write", 32'h0, count);
        wr(`TEC_IDX_HIGH, 8'h12);
        tick(2);
        chk("count loaded", 32'h1234, count);
        wr(`TEC_IDX_LOW, 8'h77);
        rd(`TEC_IDX_HIGH, 8'h12, "high read");
        rd(`TEC_IDX_LOW, 8'h34, "low read");
        wr(`TEC_IDX_IRQ, 8'h01);
        wr(`TEC_IDX_LOW, 8'hF0);
        wr(`TEC_IDX_HIGH, 8'hFF);
        wr(`TEC_IDX_CTRL, 8'h90);
        for (int p = 0; p < 2; p++) begin
            v = count;
            k = 0;
            while (count === v && k < 10) begin
                tick(1);
                k++;
            end
        end
        chk("timer step", 32'd4, k);
        wr(`TEC_IDX_LOW, 8'h00);
        wr(`TEC_IDX_HIGH, 8'h80);
        tick(2);
        chk("running count kept", 32'hF, count[15:12]);
        w0 = wakes;
        k = 0;
        while (count !== 16'h8000 && k < 200) begin
            tick(1);
            k++;
        end
        chk("reload value", 32'h8000, count);
        tick(2);
        chk("wake pulses", w0 + 1, wakes);
        chk("irq out", 32'h1, irq);
        rd(`TEC_IDX_IRQ, 8'h41, "flag set");
        rd(`TEC_IDX_CTRL, 8'h90, "enable kept");
        wr(`TEC_IDX_IRQ, 8'h40);
        tick(2);
        chk("irq masked", 32'h0, irq);
        wr(`TEC_IDX_IRQ, 8'h00);
        wr(`TEC_IDX_CTRL, 8'h80);
        tick(1);
        v = count;
        tick(12);
        chk("stopped", v, count);
        level(1'b1);
        wr(`TEC_IDX_LOW, 8'h00);
        wr(`TEC_IDX_HIGH, 8'h00);
        wr(`TEC_IDX_CTRL, 8'h58);
        level(1'b0);
        chk("falling counted", 32'h1, count);
        level(1'b1);
        chk("rising ignored", 32'h1, count);
        pulses(8'd3, 8'd4);
        chk("event count", 32'h4, count);
        wr(`TEC_IDX_CTRL, 8'h48);
        pulses(8'd3, 8'd4);
        chk("disabled count", 32'h4, count);
        wr(`TEC_IDX_CTRL, 8'h18);
        pulses(8'd3, 8'd4);
        chk("mode off count", 32'h4, count);
        wr(`TEC_IDX_CTRL, 8'h08);
        wr(`TEC_IDX_LOW, 8'h00);
        wr(`TEC_IDX_HIGH, 8'h00);
        wr(`TEC_IDX_CTRL, 8'hD0);
        tick(20);
        level(1'b0);
        chk("level ignored", 32'h0, count);
        pulses(8'd1, 8'd40);
        chk("width", 32'h1, count >= 16'd9 && count <= 16'd11);
        rd(`TEC_IDX_CTRL, 8'hC0, "enable cleared");
        v = count;
        pulses(8'd1, 8'd40);
        chk("result held", v, count);
        wr(`TEC_IDX_CTRL, 8'hD0);
        pulses(8'd1, 8'd20);
        chk("rearmed", 32'h1, count > v);
        wr(`TEC_IDX_LOW, 8'hF8);
        wr(`TEC_IDX_HIGH, 8'hFF);
        wr(`TEC_IDX_CTRL, 8'hD0);
        wr(`TEC_IDX_LOW, 8'h00);
        wr(`TEC_IDX_HIGH, 8'h50);
        w0 = wakes;
        pulses(8'd1, 8'd40);
        chk("pulse reload", 32'h50, count[15:8]);
        chk("pulse wake", w0 + 1, wakes);
        rd(`TEC_IDX_IRQ, 8'h40, "pulse flag");
        wr(`TEC_IDX_CTRL, 8'h50);
        v = count;
        pulses(8'd2, 8'd4);
        chk("rising counted", v + 16'h0002, count);
        report_and_stop;
    end
endmodule : test_timer_event_counter_16bit
